// File: rtl/cmad_decoder.sv
// address decoder of the core module: steers each processor access
// to SRAM, boot memory, SDRAM, registers, system bus or abort
// assumes requests are one-cycle strobes on I_CLK, and that the
// register block sits outside and sees the same write to control
`timescale 1ns/100ps
module cmad_decoder #(
   parameter int STACK_W = 2
) (
   // clock, reset, enable
   input wire logic I_CLK,
   input wire logic I_RSTN,
   input wire logic I_CE,
   // pins from the board stack
   input wire logic I_BOARD_ATTACH_DETECT_N,
   input wire logic [STACK_W-1:0] I_STACK_POS,
   // fitted SDRAM size code, same clock
   input wire logic [2:0] I_SDRAM_SZ,
   // processor access
   input wire logic I_REQ,
   input wire logic I_WRITE,
   input wire logic [31:0] I_ADDR,
   input wire logic [31:0] I_WDATA,
   // routed access
   output logic O_VALID,
   output logic [2:0] O_TGT,
   output logic [31:0] O_ADDR,
   // inbound system bus access
   input wire logic I_SB_REQ,
   input wire logic [31:0] I_SB_ADDR,
   output logic O_SB_HIT,
   output logic [31:0] O_SB_ADDR,
   // status for module_status_reg
   output logic O_ATTACHED,
   output logic O_REMAP,
   output logic [STACK_W-1:0] O_STACK_POS,
   output logic [31:0] O_ALIAS_BASE
);
   if (STACK_W < 1 || STACK_W > 4) begin : g_bad_stack
      $error("cmad_decoder: STACK_W must be 1 to 4");
   end

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // fold an address into the fitted SDRAM so smaller parts repeat
   function automatic logic [31:0] fold(input logic [31:0] a,
                                        input logic [2:0] sz);
      logic [2:0] c;
      logic [31:0] m;
      c = (sz > cmad_pkg::SZ_CODE_MAX) ? cmad_pkg::SZ_CODE_MAX : sz;
      m = (32'h0000_0001 << (cmad_pkg::SZ_LOG2_MIN + int'(c))) - 32'h1;
      return a & m; // R6
   endfunction : fold

   // pick the target of a processor address
   function automatic cmad_pkg::cmad_tgt_t decode(input logic [31:0] a,
                                                  input logic att,
                                                  input logic rmp);
      if (a < cmad_pkg::LOW_SIZE) begin
         // remap counts only while attached
         decode = (att && !rmp) ? cmad_pkg::TGT_BOOT // R1 R4
                                : cmad_pkg::TGT_SRAM; // R2 R3
      end else if (a < cmad_pkg::SDRAM_TOP) begin
         decode = cmad_pkg::TGT_SDRAM; // R5 R7
      end else if (a < cmad_pkg::SRAM_ALIAS_BASE) begin
         decode = cmad_pkg::TGT_REGS; // R16
      end else if (a < cmad_pkg::SYSBUS_BASE) begin
         decode = cmad_pkg::TGT_SRAM; // R9
      end else begin
         // own alias included: goes out and back over the bus
         decode = att ? cmad_pkg::TGT_SYSBUS // R10 R14
                      : cmad_pkg::TGT_ABORT; // R17
      end
   endfunction : decode

   // ----------------------------------------------------------------
   // reset release and pin capture
   // ----------------------------------------------------------------
   logic rst_s1;
   logic rst_n;
   logic det_n;
   logic [STACK_W-1:0] pos;

   // async assert, release through two flops
   always_ff @(posedge I_CLK or negedge I_RSTN) begin
      if (!I_RSTN) begin
         rst_s1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_s1 <= 1'b1;
         rst_n <= rst_s1;
      end
   end

   // detect idles high: the far side grounds it when fitted
   cmad_pin_sync #(.W(1), .RST(1'b1)) u_det_sync ( // R15
      .clk(I_CLK),
      .rst_n(rst_n),
      .ce(I_CE),
      .d(I_BOARD_ATTACH_DETECT_N),
      .q(det_n)
   );

   cmad_pin_sync #(.W(STACK_W), .RST('0)) u_pos_sync (
      .clk(I_CLK),
      .rst_n(rst_n),
      .ce(I_CE),
      .d(I_STACK_POS),
      .q(pos)
   );

   // ----------------------------------------------------------------
   // remap shadow and status
   // ----------------------------------------------------------------
   cmad_pkg::cmad_req_t req;
   logic remap;
   logic next_remap;
   logic attached;
   logic [STACK_W-1:0] stack_pos;
   logic [31:0] alias_base;
   logic [31:0] next_alias_base;

   assign req = '{valid: I_REQ, write: I_WRITE, addr: I_ADDR,
                  wdata: I_WDATA};

   // remap follows word writes to module_control_reg
   always_comb begin
      next_remap = remap;
      if (req.valid && req.write && req.addr == cmad_pkg::CTRL_ADDR) begin
         next_remap = req.wdata[cmad_pkg::REMAP_BIT]; // R4
      end
      // alias base derived from stack slot, never from software
      next_alias_base = cmad_pkg::ALIAS_BASE0
                      + cmad_pkg::ALIAS_STEP * 32'(pos); // R12
   end

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         remap <= cmad_pkg::REMAP_RST; // R1
         attached <= 1'b0;
         stack_pos <= '0;
         alias_base <= cmad_pkg::ALIAS_BASE0;
      end else if (I_CE) begin
         remap <= next_remap;
         attached <= !det_n;
         stack_pos <= pos; // R13
         alias_base <= next_alias_base; // R13
      end
   end

   // ----------------------------------------------------------------
   // local route, one cycle after the request
   // ----------------------------------------------------------------
   cmad_pkg::cmad_route_t route;
   cmad_pkg::cmad_route_t next_route;

   // decode uses the attach and remap state held before this request
   always_comb begin
      next_route.valid = req.valid;
      next_route.tgt = cmad_pkg::TGT_NONE;
      next_route.addr = 32'h0000_0000;
      if (req.valid) begin
         next_route.tgt = decode(req.addr, attached, remap);
         case (next_route.tgt)
            cmad_pkg::TGT_SDRAM: begin
               next_route.addr = fold(req.addr, I_SDRAM_SZ); // R6
            end
            cmad_pkg::TGT_SRAM: begin
               next_route.addr = req.addr & cmad_pkg::SRAM_MASK; // R9
            end
            cmad_pkg::TGT_REGS: begin
               next_route.addr = req.addr & cmad_pkg::REG_MASK;
            end
            cmad_pkg::TGT_BOOT, cmad_pkg::TGT_SYSBUS: begin
               next_route.addr = req.addr;
            end
            default: begin
               next_route.addr = 32'h0000_0000;
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         route <= '{valid: 1'b0, tgt: cmad_pkg::TGT_NONE, addr: '0};
      end else if (I_CE) begin
         route <= next_route;
      end
   end

   // ----------------------------------------------------------------
   // inbound route: other masters reach SDRAM at the alias
   // ----------------------------------------------------------------
   logic sb_hit;
   logic next_sb_hit;
   logic [31:0] sb_addr;
   logic [31:0] next_sb_addr;
   logic [31:0] sb_off;

   // only while on a board is there a bus to come from
   always_comb begin
      sb_off = I_SB_ADDR - alias_base;
      next_sb_hit = I_SB_REQ && attached && I_SB_ADDR >= alias_base
                 && sb_off < cmad_pkg::ALIAS_STEP; // R11
      // the whole window, first 256KB included, lands in SDRAM
      next_sb_addr = next_sb_hit ? fold(sb_off, I_SDRAM_SZ) // R8
                                 : 32'h0000_0000;
   end

   always_ff @(posedge I_CLK or negedge rst_n) begin
      if (!rst_n) begin
         sb_hit <= 1'b0;
         sb_addr <= '0;
      end else if (I_CE) begin
         sb_hit <= next_sb_hit;
         sb_addr <= next_sb_addr;
      end
   end

   // outputs straight from flops
   assign O_VALID = route.valid;
   assign O_TGT = route.tgt;
   assign O_ADDR = route.addr;
   assign O_SB_HIT = sb_hit;
   assign O_SB_ADDR = sb_addr;
   assign O_ATTACHED = attached;
   assign O_REMAP = remap;
   assign O_STACK_POS = stack_pos;
   assign O_ALIAS_BASE = alias_base;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence low_req_s;
      I_CE && I_REQ && I_ADDR < cmad_pkg::LOW_SIZE;
   endsequence
   sequence high_req_s;
      I_CE && I_REQ && I_ADDR >= cmad_pkg::SYSBUS_BASE;
   endsequence

   boot_route_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R1
      low_req_s and attached && !remap |=> O_VALID
         && O_TGT == cmad_pkg::TGT_BOOT)
      else $error("boot memory not selected");
   sram_remap_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R2
      low_req_s and attached && remap |=> O_TGT == cmad_pkg::TGT_SRAM
         && O_ADDR == ($past(I_ADDR) & cmad_pkg::SRAM_MASK))
      else $error("remapped low access not in SRAM");
   sram_alone_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R3
      low_req_s and !attached |=> O_TGT == cmad_pkg::TGT_SRAM)
      else $error("detached low access not in SRAM");
   remap_write_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R4
      I_CE && I_REQ && I_WRITE && I_ADDR == cmad_pkg::CTRL_ADDR
         |=> remap == $past(I_WDATA[cmad_pkg::REMAP_BIT]))
      else $error("remap bit not taken from control write");
   remap_reset_a: assert property (@(posedge I_CLK) // R4
      $rose(rst_n) |-> !remap)
      else $error("remap not clear after reset");
   sdram_fold_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R6
      I_CE && I_REQ && I_ADDR >= cmad_pkg::LOW_SIZE
         && I_ADDR < cmad_pkg::SDRAM_TOP |=> O_TGT == cmad_pkg::TGT_SDRAM
         && O_ADDR == fold($past(I_ADDR), $past(I_SDRAM_SZ)))
      else $error("SDRAM access misrouted");
   sram_alias_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R9
      I_CE && I_REQ && I_ADDR >= cmad_pkg::SRAM_ALIAS_BASE
         && I_ADDR < cmad_pkg::SYSBUS_BASE |=> O_TGT == cmad_pkg::TGT_SRAM
         && O_ADDR[31:18] == 14'h0000)
      else $error("SRAM alias misrouted");
   high_route_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R10
      high_req_s |=> O_TGT == ($past(attached) ? cmad_pkg::TGT_SYSBUS
                                                : cmad_pkg::TGT_ABORT))
      else $error("high access neither bus nor abort");
   regs_route_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R16
      I_CE && I_REQ && I_ADDR >= cmad_pkg::REG_BASE
         && I_ADDR < cmad_pkg::SRAM_ALIAS_BASE
         |=> O_TGT == cmad_pkg::TGT_REGS)
      else $error("register region misrouted");
   alias_hit_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R8
      I_CE && I_SB_REQ && attached && I_SB_ADDR == alias_base
         |=> O_SB_HIT && O_SB_ADDR == 32'h0000_0000)
      else $error("alias base not mapped to SDRAM zero");
   alias_pos_a: assert property (@(posedge I_CLK) disable iff (!rst_n) // R12
      I_CE && $stable(pos) ##1 I_CE |=> O_ALIAS_BASE
         == cmad_pkg::ALIAS_BASE0 + cmad_pkg::ALIAS_STEP * 32'($past(pos)))
      else $error("alias base does not follow stack slot");
endmodule : cmad_decoder

// File: rtl/cmad_pkg.sv
// constants and types of the core module address decoder
// assumes one processor bus clock and 32-bit byte addresses
//
// Behaviour
// (R1) board attached, remap clear after reset: low 256KB goes to boot memory
// (R2) board attached, remap set: low 256KB goes to on-board synchronous SRAM
// (R3) no board attached: low 256KB always goes to synchronous SRAM
// (R4) remap bit, bit two of control register, matters only while attached
// (R5) 256MB SDRAM window from zero; accesses from 0x00040000 reach SDRAM
// (R6) smaller SDRAM fitted: upper address bits ignored, image repeats
// (R7) lowest 256KB never reaches SDRAM; use repeat image or alias
// (R8) full 256MB SDRAM: first 256KB reachable only via global alias
// (R9) 8MB region at 0x10800000 reaches SRAM, 256KB image repeating
// (R10) attached: accesses at or above 0x11000000 go to the system bus
// (R11) SDRAM reachable by all bus masters at alias, locally at both
// (R12) global alias base follows stack position, no software setting
// (R13) status shows stack position so software finds its alias address
// (R14) local access to own alias address travels out over system bus
// (R15) attached motherboard holds attach-detect line permanently low
// (R16) 8MB region at 0x10000000 decodes to the module register block
// (R17) no board attached: accesses at or above 0x11000000 abort
package cmad_pkg;
   // ----------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------
   localparam logic [31:0] LOW_SIZE = 32'h0004_0000;
   localparam logic [31:0] SDRAM_TOP = 32'h1000_0000;
   localparam logic [31:0] REG_BASE = 32'h1000_0000;
   localparam logic [31:0] SRAM_ALIAS_BASE = 32'h1080_0000;
   localparam logic [31:0] SYSBUS_BASE = 32'h1100_0000;
   localparam logic [31:0] SRAM_MASK = 32'h0003_FFFF;
   localparam logic [31:0] REG_MASK = 32'h007F_FFFF;
   // module_control_reg address and remap field position
   localparam logic [31:0] CTRL_ADDR = 32'h1000_000C;
   localparam int REMAP_BIT = 2;
   localparam logic REMAP_RST = 1'b0;
   // global alias of local SDRAM: base plus position times window
   localparam logic [31:0] ALIAS_BASE0 = 32'h8000_0000;
   localparam logic [31:0] ALIAS_STEP = 32'h1000_0000;
   // fitted SDRAM size code: log2 bytes is SZ_LOG2_MIN plus code
   localparam int SZ_LOG2_MIN = 24;
   localparam logic [2:0] SZ_CODE_MAX = 3'h4;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      TGT_NONE = 3'b000,
      TGT_SRAM = 3'b001,
      TGT_BOOT = 3'b010,
      TGT_SDRAM = 3'b011,
      TGT_REGS = 3'b100,
      TGT_SYSBUS = 3'b101,
      TGT_ABORT = 3'b110
   } cmad_tgt_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [31:0] wdata;
   } cmad_req_t;

   typedef struct packed {
      logic valid;
      cmad_tgt_t tgt;
      logic [31:0] addr;
   } cmad_route_t;
endpackage : cmad_pkg

// File: rtl/cmad_pin_sync.sv
// three-stage synchroniser with agreement filter for slow pins
// assumes the pin changes rarely compared with the clock
`timescale 1ns/100ps
module cmad_pin_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '0
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // pin in, filtered level out
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;
   logic [W-1:0] next_q;

   if (W < 1) begin : g_bad_w
      $error("cmad_pin_sync: width below one");
   end

   // change taken once the second and third stages agree
   always_comb begin
      next_q = (s2 == s3) ? s3 : q;
   end

   // s1 feeds s2 only, to keep metastability away from the filter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1 <= RST;
         s2 <= RST;
         s3 <= RST;
         q <= RST;
      end else if (ce) begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
         q <= next_q;
      end
   end
endmodule : cmad_pin_sync

// File: tb/cmad_cpu_model.sv
// processor side model: issues one access per call, one-cycle strobe
// assumes the decoder takes the request at the next rising edge
`timescale 1ns/100ps
module cmad_cpu_model (
   // clock
   input wire logic i_clk,
   // access towards the decoder
   output logic o_req,
   output logic o_write,
   output logic [31:0] o_addr,
   output logic [31:0] o_wdata
);
   // --------------------------------------------------------------
   // idle bus
   // --------------------------------------------------------------
   // released lines show the inverse, so a stale value never passes
   initial begin
      o_req = 1'b0;
      o_write = 1'b0;
      o_addr = 32'h0000_0000;
      o_wdata = 32'h0000_0000;
   end

   // --------------------------------------------------------------
   // one access: set after an edge, held through the taking edge
   // --------------------------------------------------------------
   task issue(input logic [31:0] a, input logic w, input logic [31:0] d);
      @(posedge i_clk);
      o_req <= 1'b1;
      o_write <= w;
      o_addr <= a;
      o_wdata <= d;
      @(posedge i_clk);
      o_req <= 1'b0;
      o_write <= ~w;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask : issue
endmodule : cmad_cpu_model

// File: tb/core_module_address_decoder_test.sv
// self-checking bench of the address decoder
// assumes design assertions sit inside the design files
`timescale 1ns/100ps
module core_module_address_decoder_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic det_n = 1'b1;
   logic [1:0] pos = 2'b00;
   logic [2:0] sz = 3'h0;
   logic req, wr, sb_req = 1'b0;
   logic [31:0] addr, wdata, sb_addr = 32'h0000_0000;
   logic valid, sb_hit, attached, remap;
   logic [2:0] tgt;
   logic [1:0] spos;
   logic [31:0] raddr, sbo, abase;
   logic att = 1'b0;
   logic rmp = 1'b0;
   logic ce = 1'b1;
   integer seed = 41325;
   int fail_count = 0;
   int n_checks = 0;
   int cyc = 0;
   logic [31:0] corner [10] = '{32'h0000_0000, 32'h0003_FFFF,
      32'h0004_0000, 32'h0FFF_FFFF, 32'h1000_0000, 32'h107F_FFFF,
      32'h1080_0000, 32'h10FF_FFFF, 32'h1100_0000, 32'hFFFF_FFFF};

   always #10 clk = ~clk;

   cmad_decoder #(.STACK_W(2)) cmad_decoder_i (
      .I_CLK(clk), .I_RSTN(rstn), .I_CE(ce),
      .I_BOARD_ATTACH_DETECT_N(det_n), .I_STACK_POS(pos),
      .I_SDRAM_SZ(sz), .I_REQ(req), .I_WRITE(wr), .I_ADDR(addr),
      .I_WDATA(wdata), .O_VALID(valid), .O_TGT(tgt), .O_ADDR(raddr),
      .I_SB_REQ(sb_req), .I_SB_ADDR(sb_addr), .O_SB_HIT(sb_hit),
      .O_SB_ADDR(sbo), .O_ATTACHED(attached), .O_REMAP(remap),
      .O_STACK_POS(spos), .O_ALIAS_BASE(abase));

   cmad_cpu_model cmad_cpu_model_i (
      .i_clk(clk), .o_req(req), .o_write(wr), .o_addr(addr),
      .o_wdata(wdata));

   // --------------------------------------------------------------
   // expectations
   // --------------------------------------------------------------
   // fitted size mask; codes above four read as the full 256MB
   function logic [31:0] szm(input logic [2:0] c);
      return (32'h0000_0001 << (24 + ((c > 3'h4) ? 4 : int'(c)))) - 1;
   endfunction : szm

   function logic [31:0] abexp();
      return 32'h8000_0000 + (32'(pos) << 28);
   endfunction : abexp

   function logic [34:0] exp_rt(input logic [31:0] a);
      if (a < 32'h0004_0000)
         return (att && !rmp) ? {cmad_pkg::TGT_BOOT, a}
                              : {cmad_pkg::TGT_SRAM, a};
      if (a < 32'h1000_0000)
         return {cmad_pkg::TGT_SDRAM, a & szm(sz)};
      if (a < 32'h1080_0000)
         return {cmad_pkg::TGT_REGS, a & 32'h007F_FFFF};
      if (a < 32'h1100_0000)
         return {cmad_pkg::TGT_SRAM, a & 32'h0003_FFFF};
      return att ? {cmad_pkg::TGT_SYSBUS, a}
                 : {cmad_pkg::TGT_ABORT, 32'h0000_0000};
   endfunction : exp_rt

   // --------------------------------------------------------------
   // compare, access and closing tasks
   // --------------------------------------------------------------
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task end_sim;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_sim

   task go(input logic [31:0] a, input logic w, input logic [31:0] d);
      logic [34:0] e;
      cmad_cpu_model_i.issue(a, w, d);
      #1;
      e = exp_rt(a);
      chk("valid", 32'h0000_0001, 32'(valid));
      chk("target", 32'(e[34:32]), 32'(tgt));
      chk("route addr", e[31:0], raddr);
      if (w && a == cmad_pkg::CTRL_ADDR)
         rmp = d[cmad_pkg::REMAP_BIT];
      chk("remap", 32'(rmp), 32'(remap));
   endtask : go

   task sb(input logic [31:0] a);
      logic [31:0] o;
      @(posedge clk);
      sb_req <= 1'b1;
      sb_addr <= a;
      @(posedge clk);
      sb_req <= 1'b0;
      sb_addr <= ~a;
      #1;
      o = a - abexp();
      chk("sb hit", 32'(att && o < 32'h1000_0000), 32'(sb_hit));
      chk("sb addr", (att && o < 32'h1000_0000) ? o & szm(sz)
         : 32'h0000_0000, sbo);
   endtask : sb

   task set_att(input logic v);
      @(posedge clk);
      det_n <= ~v;
      repeat (8) @(posedge clk);
      #1;
      att = v;
      chk("attached", 32'(v), 32'(attached));
   endtask : set_att

   // hang guard: whole run needs about 550 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_sim();
      end
   end

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      pos = 2'($random(seed));
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      // two reset flops, three sync flops, filter, then status flop
      repeat (8) @(posedge clk);
      #1;
      chk("alias base", abexp(), abase);
      chk("stack pos", 32'(pos), 32'(spos));
      for (int v = 0; v < 2; v++) begin
         set_att(v[0]);
         for (int r = 0; r < 2; r++) begin
            go(cmad_pkg::CTRL_ADDR, 1'b1, 32'(r) << 2);
            go(cmad_pkg::CTRL_ADDR, 1'b0, 32'hFFFF_FFFF);
            foreach (corner[k])
               go(corner[k], 1'b0, 32'h0000_0000);
            go(abexp() + 32'h0000_0100, 1'b0, 32'h0000_0000);
            for (int i = 0; i < 30; i++) begin
               @(posedge clk);
               sz <= 3'($random(seed));
               addr_rand(i);
            end
         end
         sb(abexp() + ($random(seed) & 32'h0FFF_FFFF));
         sb(abexp() - 32'h0000_0001);
         sb(abexp());
         sb(abexp() + 32'h0FFF_FFFF);
         sb($random(seed));
      end
      // second reset in mid-run clears the remap shadow
      @(posedge clk);
      rstn <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk("remap in reset", 32'h0000_0000, 32'(remap));
      chk("valid in reset", 32'h0000_0000, 32'(valid));
      @(posedge clk);
      rstn <= 1'b1;
      att = 1'b0;
      rmp = 1'b0;
      repeat (3) @(posedge clk);
      set_att(1'b1);
      go(32'h0000_0100, 1'b0, 32'h0000_0000);
      // low enable freezes route and remap across a control write
      @(posedge clk);
      ce <= 1'b0;
      cmad_cpu_model_i.issue(cmad_pkg::CTRL_ADDR, 1'b1, 32'h0000_0004);
      #1;
      chk("frozen valid", 32'h0000_0000, 32'(valid));
      chk("frozen remap", 32'h0000_0000, 32'(remap));
      @(posedge clk);
      ce <= 1'b1;
      end_sim();
   end

   // random address, every third one pulled into the low 512KB
   task addr_rand(input int i);
      logic [31:0] a;
      a = $random(seed);
      if (i % 3 == 0)
         a = a & 32'h0007_FFFF;
      go(a, 1'($random(seed)), $random(seed));
   endtask : addr_rand
endmodule : core_module_address_decoder_test
